// file: logic/ddtc_pkg.sv
// Package with types and constants for the descriptor trigger and transfer control block.
package ddtc_pkg;

    // Element size encodings.
    typedef enum logic [1:0] {
        ELEMENT_SIZE_BYTE,
        ELEMENT_SIZE_HALFWORD,
        ELEMENT_SIZE_WORD
    } ddtc_size_e;

    // Source and destination access width selections.
    typedef enum logic [1:0] {
        WIDTH_ELEMENT_BOTH_SIDES,
        WIDTH_ELEMENT_WORD,
        WIDTH_WORD_ELEMENT,
        WIDTH_WORD_WORD
    } ddtc_width_e;

    // Trigger type encodings.
    typedef enum logic [1:0] {
        PULSE_TRIGGER_TYPE,
        LEVEL_TRIGGER_WAIT_FOUR,
        LEVEL_TRIGGER_WAIT_EIGHT,
        UNBOUNDED_PULSE_TRIGGER_TYPE
    } ddtc_trig_e;

    // Transfer mode encodings.
    typedef enum logic [1:0] {
        ONE_ELEMENT_PER_TRIGGER_MODE,
        WHOLE_DESCRIPTOR_MODE,
        WHOLE_DESCRIPTOR_CHAINED_MODE
    } ddtc_mode_e;

    // Byte counts used for address steps and access sizes.
    localparam logic [2:0] BYTES_BYTE = 3'h1;
    localparam logic [2:0] BYTES_HALFWORD = 3'h2;
    localparam logic [2:0] BYTES_WORD = 3'h4;

    // Level trigger wait limits in system clock cycles.
    localparam logic [3:0] LEVEL_WAIT_FOUR_CYCLES = 4'h4;
    localparam logic [3:0] LEVEL_WAIT_EIGHT_CYCLES = 4'h8;

    // Default element count field width.
    localparam int COUNT_WIDTH = 17;

    // One descriptor's configuration as written by software.
    typedef struct packed {
        logic [31:0] source_address;
        logic [31:0] destination_address;
        logic [16:0] element_count;
        ddtc_size_e element_size;
        ddtc_width_e width_select;
        logic source_increment_enable;
        logic destination_increment_enable;
        ddtc_trig_e trigger_type;
        ddtc_mode_e transfer_mode;
        logic chain_action_enable;
    } ddtc_desc_s;

    // One memory bus element request.
    typedef struct packed {
        logic [31:0] read_address;
        logic [31:0] write_address;
        logic [2:0] read_bytes;
        logic [2:0] write_bytes;
    } ddtc_xfer_s;

endpackage

// file: logic/ddtc_trigger_gate.sv
// Trigger qualifier: synchroniser, edge and level hold-off per trigger type.
`timescale 1ns/1ps
module ddtc_trigger_gate
    import ddtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Raw trigger and active trigger type.
    input wire logic trigger_in,
    input wire ddtc_trig_e trigger_type,
    // Engine handshake.
    input wire logic action_done,
    input wire logic engine_busy,
    output logic request
);

    typedef enum {GATE_READY, GATE_BUSY, GATE_WAIT_COUNT, GATE_WAIT_LOW} ddtc_gate_e;

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    ddtc_gate_e state_r;
    ddtc_gate_e state_nxt;
    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic [3:0] limit;

    // Two stages before any logic sees the pin.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= trigger_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign limit = (trigger_type == LEVEL_TRIGGER_WAIT_EIGHT) ? LEVEL_WAIT_EIGHT_CYCLES : LEVEL_WAIT_FOUR_CYCLES;

    // Decides when a trigger may start an action and what hold-off follows.
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        request = 1'b0;
        case (state_r)
            GATE_READY: begin
                if (!engine_busy) begin
                    if (trigger_type == PULSE_TRIGGER_TYPE) begin
                        request = sync2_r && !prev_r;
                    end else begin
                        request = sync2_r;
                    end
                end
                if (request) begin
                    state_nxt = GATE_BUSY;
                end
            end
            GATE_BUSY: begin
                if (action_done) begin
                    count_nxt = 4'h0;
                    if (trigger_type == UNBOUNDED_PULSE_TRIGGER_TYPE) begin
                        state_nxt = GATE_WAIT_LOW;
                    end else if (trigger_type != PULSE_TRIGGER_TYPE && sync2_r) begin
                        state_nxt = GATE_WAIT_COUNT;
                    end else begin
                        state_nxt = GATE_READY;
                    end
                end
            end
            GATE_WAIT_COUNT: begin
                // Count system clock cycles until the limit or the trigger falls.
                count_nxt = count_r + 4'h1;
                if (!sync2_r || count_nxt == limit) begin
                    state_nxt = GATE_READY;
                end
            end
            GATE_WAIT_LOW: begin
                // Stalls forever if the source never releases its trigger.
                if (!sync2_r) begin
                    state_nxt = GATE_READY;
                end
            end
            default: begin
                state_nxt = GATE_READY;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= GATE_READY;
            count_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

endmodule

// file: logic/ddtc_engine.sv
// Per-descriptor DMA transfer control: descriptors, trigger gating, addressing and chaining.
`timescale 1ns/1ps
module ddtc_engine
    import ddtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Descriptor configuration write port.
    input wire logic config_write,
    input wire logic config_index,
    input wire ddtc_desc_s config_data,
    // Descriptor read back.
    input wire logic readback_index,
    output ddtc_desc_s readback_data,
    // Channel enable and trigger input.
    input wire logic channel_enable,
    input wire logic trigger_in,
    // Memory bus element requests.
    output logic xfer_valid,
    output ddtc_xfer_s xfer,
    input wire logic xfer_done,
    // Status.
    output logic active_r,
    output logic active_index_r,
    output logic [COUNT_WIDTH-1:0] remaining_r,
    output logic descriptor_done_r
);

    // Idle, put one element request out, then wait for the memory side to answer it.
    typedef enum {ENG_IDLE, ENG_ISSUE, ENG_WAIT} ddtc_eng_e;

    ddtc_desc_s desc_r [2];
    ddtc_desc_s readback_nxt;
    ddtc_desc_s cur;
    ddtc_eng_e state_r;
    ddtc_eng_e state_nxt;
    logic cur_index_r;
    logic cur_index_nxt;
    logic [31:0] src_r;
    logic [31:0] src_nxt;
    logic [31:0] dst_r;
    logic [31:0] dst_nxt;
    logic [COUNT_WIDTH-1:0] remaining_nxt;
    logic chain_pending_r;
    logic chain_pending_nxt;
    logic xfer_valid_nxt;
    ddtc_xfer_s xfer_nxt;
    logic done_nxt;
    logic active_nxt;
    logic action_done;
    logic request;
    logic gate_busy;
    logic [2:0] src_step;
    logic [2:0] dst_step;

    // Byte count of one element of the given size.
    function automatic logic [2:0] size_bytes(input ddtc_size_e s);
        case (s)
            ELEMENT_SIZE_BYTE: size_bytes = BYTES_BYTE;
            ELEMENT_SIZE_HALFWORD: size_bytes = BYTES_HALFWORD;
            default: size_bytes = BYTES_WORD;
        endcase
    endfunction

    // Access width on one side: word when selected, else the element size.
    function automatic logic [2:0] side_bytes(input ddtc_desc_s d, input logic word_sel);
        side_bytes = word_sel ? BYTES_WORD : size_bytes(d.element_size);
    endfunction

    assign cur = desc_r[cur_index_r];
    assign src_step = side_bytes(cur, cur.width_select == WIDTH_WORD_ELEMENT || cur.width_select == WIDTH_WORD_WORD);
    assign dst_step = side_bytes(cur, cur.width_select == WIDTH_ELEMENT_WORD || cur.width_select == WIDTH_WORD_WORD);
    assign readback_nxt = desc_r[readback_index];

    // The gate must not take a trigger while an element or a chained start is in flight,
    // so pulses that arrive then are lost rather than queued.
    assign gate_busy = (state_r != ENG_IDLE) || chain_pending_r || !channel_enable;

    // Trigger qualification for the descriptor in use.
    ddtc_trigger_gate u_gate (
        .clk(clk),
        .rst_n(rst_n),
        .trigger_in(trigger_in),
        .trigger_type(cur.trigger_type),
        .action_done(action_done),
        .engine_busy(gate_busy),
        .request(request)
    );

    // Descriptor storage; each index keeps its own settings.
    // Writes are not blocked while a descriptor runs; software checks active_r first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            desc_r[0] <= '0;
            desc_r[1] <= '0;
        end else if (config_write) begin
            desc_r[config_index] <= config_data;
        end
    end

    // Sequencing of elements, address stepping and chaining.
    always_comb begin
        state_nxt = state_r;
        cur_index_nxt = cur_index_r;
        src_nxt = src_r;
        dst_nxt = dst_r;
        remaining_nxt = remaining_r;
        chain_pending_nxt = chain_pending_r;
        xfer_valid_nxt = 1'b0;
        xfer_nxt = xfer;
        done_nxt = 1'b0;
        action_done = 1'b0;
        case (state_r)
            ENG_IDLE: begin
                if (chain_pending_r || request) begin
                    chain_pending_nxt = 1'b0;
                    // A chained start always loads the other descriptor; a trigger reloads only when
                    // nothing is half done, so a partly moved descriptor resumes at its current addresses.
                    if (chain_pending_r || !active_r) begin
                        src_nxt = cur.source_address;
                        dst_nxt = cur.destination_address;
                        remaining_nxt = cur.element_count;
                    end
                    state_nxt = ENG_ISSUE;
                end
            end
            ENG_ISSUE: begin
                // One element request; it stands unchanged until the memory side answers.
                xfer_valid_nxt = 1'b1;
                xfer_nxt.read_address = src_r;
                xfer_nxt.write_address = dst_r;
                xfer_nxt.read_bytes = src_step;
                xfer_nxt.write_bytes = dst_step;
                state_nxt = ENG_WAIT;
            end
            ENG_WAIT: begin
                xfer_valid_nxt = !xfer_done;
                if (xfer_done) begin
                    // Fixed addresses when the flag is clear.
                    if (cur.source_increment_enable) begin
                        src_nxt = src_r + {29'h0, src_step};
                    end
                    if (cur.destination_increment_enable) begin
                        dst_nxt = dst_r + {29'h0, dst_step};
                    end
                    remaining_nxt = remaining_r - 17'h1;
                    // The last element ends the action, whatever the mode.
                    if (remaining_nxt == '0) begin
                        state_nxt = ENG_IDLE;
                        action_done = 1'b1;
                        done_nxt = 1'b1;
                        if (cur.transfer_mode == WHOLE_DESCRIPTOR_CHAINED_MODE && cur.chain_action_enable) begin
                            cur_index_nxt = !cur_index_r;
                            chain_pending_nxt = 1'b1;
                        end
                    end else if (cur.transfer_mode == ONE_ELEMENT_PER_TRIGGER_MODE) begin
                        state_nxt = ENG_IDLE;
                        action_done = 1'b1;
                    end else begin
                        state_nxt = ENG_ISSUE;
                    end
                end
            end
            default: begin
                state_nxt = ENG_IDLE;
            end
        endcase
        // Active from the first start until the last element completes. A descriptor in
        // one-element mode stays active between triggers, which is what lets it resume.
        active_nxt = (state_nxt != ENG_IDLE) || (remaining_nxt != '0 && state_r != ENG_IDLE) ||
            (active_r && !done_nxt);
    end

    // Engine registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ENG_IDLE;
            cur_index_r <= 1'b0;
            src_r <= 32'h0;
            dst_r <= 32'h0;
            remaining_r <= '0;
            chain_pending_r <= 1'b0;
            xfer_valid <= 1'b0;
            xfer <= '0;
            descriptor_done_r <= 1'b0;
            active_r <= 1'b0;
            active_index_r <= 1'b0;
            readback_data <= '0;
        end else begin
            state_r <= state_nxt;
            cur_index_r <= cur_index_nxt;
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            remaining_r <= remaining_nxt;
            chain_pending_r <= chain_pending_nxt;
            xfer_valid <= xfer_valid_nxt;
            xfer <= xfer_nxt;
            descriptor_done_r <= done_nxt;
            active_r <= active_nxt;
            active_index_r <= cur_index_nxt;
            readback_data <= readback_nxt;
        end
    end

endmodule

// file: testbench/ddtc_engine_monitor.sv
// Checker on the engine ports: request holding, access widths, completion and chaining.
`timescale 1ns/1ps
module ddtc_engine_monitor
    import ddtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Configuration and read back.
    input wire logic config_write,
    input wire logic config_index,
    input wire ddtc_desc_s config_data,
    input wire logic readback_index,
    input wire ddtc_desc_s readback_data,
    // Trigger and memory side.
    input wire logic trigger_in,
    input wire logic xfer_valid,
    input wire ddtc_xfer_s xfer,
    input wire logic xfer_done,
    // Status.
    input wire logic active_index_r,
    input wire logic descriptor_done_r
);
    ddtc_desc_s shadow_r [2];
    ddtc_desc_s cur;
    logic cur_chain;
    logic any_chain;
    // Shadow of both descriptors, cleared by reset just as the engine clears its own.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_r[0] <= '0;
            shadow_r[1] <= '0;
        end else if (config_write) begin
            shadow_r[config_index] <= config_data;
        end
    end
    // Chaining needs both the chained mode and the chain action of the descriptor.
    assign cur = shadow_r[active_index_r];
    assign cur_chain = cur.transfer_mode == WHOLE_DESCRIPTOR_CHAINED_MODE && cur.chain_action_enable;
    assign any_chain = shadow_r[0].chain_action_enable || shadow_r[1].chain_action_enable;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_xfer_held: assert property (
        xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer)) else $error("request changed while pending");
    a_one_element: assert property (
        xfer_valid && xfer_done |=> !xfer_valid) else $error("request stayed after done");
    a_access_width: assert property (
        xfer_valid |-> xfer.read_bytes == (cur.width_select[1] ? BYTES_WORD : BYTES_BYTE << cur.element_size)
        && xfer.write_bytes == (cur.width_select[0] ? BYTES_WORD : BYTES_BYTE << cur.element_size))
        else $error("access width wrong");
    a_done_once: assert property (
        descriptor_done_r |=> !descriptor_done_r) else $error("completion pulse too long");
    a_done_cause: assert property (
        descriptor_done_r |-> $past(xfer_done) || $past(xfer_done, 2)) else $error("completion without element");
    a_readback_copy: assert property (
        1'b1 |-> readback_data == $past(shadow_r[readback_index])) else $error("read back differs");
    // The active index has already moved on when the completion pulse shows, so look one cycle back.
    a_chain_start: assert property (
        descriptor_done_r && $past(cur_chain) |-> ##[1:8] xfer_valid) else $error("chained start missing");
    a_chain_gate: assert property (
        descriptor_done_r && !any_chain && !(trigger_in || $past(trigger_in) || $past(trigger_in, 2)
        || $past(trigger_in, 3)) |=> !xfer_valid [*4]) else $error("start without trigger");
endmodule
bind ddtc_engine ddtc_engine_monitor u_ddtc_engine_monitor (.clk, .rst_n, .config_write, .config_index,
    .config_data, .readback_index, .readback_data, .trigger_in, .xfer_valid, .xfer, .xfer_done,
    .active_index_r, .descriptor_done_r);

// file: testbench/ddtc_mem_model.sv
// Memory side partner: answers each element after a chosen wait and logs it.
`timescale 1ns/1ps
module ddtc_mem_model
    import ddtc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Element requests and answer delay.
    input wire logic xfer_valid,
    input wire ddtc_xfer_s xfer,
    input wire logic [3:0] wait_cycles,
    output logic xfer_done
);
    ddtc_xfer_s log_q[$];
    int stamp_q[$];
    int cyc = 0;
    logic [3:0] cnt_r;
    // Done is one cycle, only while a request stands; slow answers test that the engine holds.
    always @(posedge clk or negedge rst_n) begin
        cyc <= cyc + 1;
        if (!rst_n) begin
            xfer_done <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            xfer_done <= 1'b0;
            if (xfer_valid && !xfer_done) begin
                if (cnt_r == 4'h0) begin
                    log_q.push_back(xfer);
                    stamp_q.push_back(cyc);
                end
                cnt_r <= (cnt_r >= wait_cycles) ? 4'h0 : cnt_r + 4'h1;
                xfer_done <= (cnt_r >= wait_cycles);
            end
        end
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the descriptor engine with a memory side model.
`timescale 1ns/1ps
module tb_top
    import ddtc_pkg::*;
;
    logic clk, rst_n, config_write, config_index, readback_index, channel_enable, trigger_in;
    logic xfer_valid, xfer_done, active_r, active_index_r, descriptor_done_r;
    logic [COUNT_WIDTH-1:0] remaining_r;
    logic [3:0] wait_cycles;
    ddtc_desc_s config_data, readback_data, d;
    ddtc_desc_s dd[2];
    ddtc_xfer_s xfer;
    int err_count = 0;
    int tests_run = 0;
    int gap[2];
    ddtc_engine u_ddtc_engine (.clk, .rst_n, .config_write, .config_index, .config_data, .readback_index,
        .readback_data, .channel_enable, .trigger_in, .xfer_valid, .xfer, .xfer_done, .active_r,
        .active_index_r, .remaining_r, .descriptor_done_r);
    ddtc_mem_model u_ddtc_mem_model (.clk, .rst_n, .xfer_valid, .xfer, .wait_cycles, .xfer_done);
    // System clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compares one value, wide enough for a whole descriptor.
    task automatic check(string name, logic [95:0] exp, logic [95:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Step of one side: a word when that side is word wide, else the element size.
    function automatic logic [31:0] step(ddtc_desc_s x, logic word_side);
        return word_side ? 32'h4 : 32'h1 << x.element_size;
    endfunction
    function automatic int nlog();
        return u_ddtc_mem_model.log_q.size();
    endfunction
    // Random descriptor with legal field values only.
    function automatic ddtc_desc_s rnd(int n, ddtc_trig_e t, ddtc_mode_e m);
        ddtc_desc_s x;
        x.source_address = $urandom;
        x.destination_address = $urandom;
        x.element_count = 17'(n);
        x.element_size = ddtc_size_e'($urandom_range(2));
        x.width_select = ddtc_width_e'($urandom_range(3));
        {x.source_increment_enable, x.destination_increment_enable} = 2'($urandom);
        x.trigger_type = t;
        x.transfer_mode = m;
        x.chain_action_enable = 1'b0;
        return x;
    endfunction
    task automatic put(logic idx, ddtc_desc_s x);
        @(posedge clk);
        config_write <= 1'b1;
        config_index <= idx;
        config_data <= x;
        @(posedge clk);
        config_write <= 1'b0;
    endtask
    // Reset first, so no descriptor is active while it is rewritten; both get the same settings.
    task automatic put_both(ddtc_desc_s x);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        put(1'b0, x);
        put(1'b1, x);
        u_ddtc_mem_model.log_q.delete();
        u_ddtc_mem_model.stamp_q.delete();
    endtask
    task automatic pulse(int len);
        @(posedge clk);
        trigger_in <= 1'b1;
        repeat (len) @(posedge clk);
        trigger_in <= 1'b0;
    endtask
    // Bounded wait for n elements, then idle long enough to catch any extra one.
    task automatic wait_n(int n);
        for (int k = 0; k < 3000 && nlog() < n; k++) @(posedge clk);
        repeat (40) @(posedge clk);
    endtask
    task automatic verify(ddtc_desc_s x, int first, int n);
        ddtc_xfer_s e;
        for (int i = 0; i < n; i++) begin
            e = u_ddtc_mem_model.log_q[first + i];
            check("read_address", 32'(x.source_address + (x.source_increment_enable ?
                i * step(x, x.width_select[1]) : 0)), e.read_address);
            check("write_address", 32'(x.destination_address + (x.destination_increment_enable ?
                i * step(x, x.width_select[0]) : 0)), e.write_address);
            check("read_bytes", step(x, x.width_select[1]), e.read_bytes);
            check("write_bytes", step(x, x.width_select[0]), e.write_bytes);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        {config_write, config_index, readback_index, trigger_in, channel_enable} = 5'h00;
        config_data = '0;
        wait_cycles = 4'h0;
        void'($urandom(79));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        channel_enable <= 1'b1;
        repeat (4) begin
            foreach (dd[i]) begin
                dd[i] = rnd($urandom_range(1, 9), ddtc_trig_e'($urandom_range(3)), ddtc_mode_e'($urandom_range(2)));
                put(1'(i), dd[i]);
            end
            foreach (dd[i]) begin
                @(posedge clk);
                readback_index <= 1'(i);
                repeat (2) @(posedge clk);
                #1 check("readback_data", dd[i], readback_data);
            end
        end
        $display("Test readback done");
        dd[0] = rnd(2, PULSE_TRIGGER_TYPE, WHOLE_DESCRIPTOR_CHAINED_MODE);
        dd[0].chain_action_enable = 1'b1;
        dd[1] = rnd(2, PULSE_TRIGGER_TYPE, WHOLE_DESCRIPTOR_MODE);
        put_both(dd[1]);
        put(1'b0, dd[0]);
        pulse(1);
        wait_n(4);
        check("elements", 4, nlog());
        verify(dd[0], 0, 2);
        verify(dd[1], 2, 2);
        check("active_index_r", 1, active_index_r);
        check("active_r", 0, active_r);
        dd[0].chain_action_enable = 1'b0;
        put_both(dd[0]);
        pulse(1);
        wait_n(2);
        check("elements", 2, nlog());
        $display("Test chain done");
        for (int k = 0; k < 16; k++) begin
            d = rnd(3, PULSE_TRIGGER_TYPE, WHOLE_DESCRIPTOR_MODE);
            d.width_select = ddtc_width_e'(k % 4);
            d.element_size = ddtc_size_e'(k % 3);
            {d.source_increment_enable, d.destination_increment_enable} = 2'(k / 4);
            wait_cycles <= 4'($urandom_range(6));
            put_both(d);
            pulse($urandom_range(1, 4));
            wait_n(3);
            check("elements", 3, nlog());
            verify(d, 0, 3);
        end
        $display("Test whole done");
        d = rnd(3, PULSE_TRIGGER_TYPE, ONE_ELEMENT_PER_TRIGGER_MODE);
        put_both(d);
        pulse(8);
        wait_n(1);
        check("elements", 1, nlog());
        check("remaining_r", 2, remaining_r);
        check("active_r", 1, active_r);
        pulse(1);
        wait_n(2);
        check("elements", 2, nlog());
        pulse(1);
        wait_n(3);
        check("elements", 3, nlog());
        check("active_r", 0, active_r);
        verify(d, 0, 3);
        $display("Test single done");
        put_both(rnd(3, UNBOUNDED_PULSE_TRIGGER_TYPE, ONE_ELEMENT_PER_TRIGGER_MODE));
        pulse(60);
        check("elements", 1, nlog());
        pulse(1);
        wait_n(2);
        check("elements", 2, nlog());
        $display("Test unbounded done");
        foreach (gap[i]) begin
            put_both(rnd(20, i ? LEVEL_TRIGGER_WAIT_EIGHT : LEVEL_TRIGGER_WAIT_FOUR, ONE_ELEMENT_PER_TRIGGER_MODE));
            trigger_in <= 1'b1;
            wait_n(3);
            trigger_in <= 1'b0;
            repeat (20) @(posedge clk);
            gap[i] = u_ddtc_mem_model.stamp_q[2] - u_ddtc_mem_model.stamp_q[1];
        end
        check("level_gap_step", 4, gap[1] - gap[0]);
        $display("Test level done");
        tally_and_finish();
    end
    // Watchdog: the sequence needs well under this many cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("Error watchdog expected finish seen timeout");
        tally_and_finish();
    end
endmodule
